//--- pkg/spm_consts.vh
// spm_consts.vh: constants of the card power-up and bus-mode select block
// assumes: included by bare name from the power-up design file under hdl/ (the link receiver does not include it)
`ifndef SPM_CONSTS_VH
`define SPM_CONSTS_VH

// -----------------------------------------------------------------
// command frame on the command line
// -----------------------------------------------------------------
`define SPM_FRAME_BITS 6'd48
`define SPM_FRAME_LAST 6'd47
`define SPM_DIR_BIT 46
`define SPM_IDX_HI 45
`define SPM_IDX_LO 40
`define SPM_RESET_IDX 6'h00

// -----------------------------------------------------------------
// initial clock run and byte framing
// -----------------------------------------------------------------
`define SPM_INIT_CLKS 7'd74
`define SPM_BYTE_LAST 3'd7

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define SPM_RST_IDLE 1'b1
`define SPM_RST_PULLUP 1'b1
`define SPM_RST_SPI 1'b0

`endif

//--- hdl/spm_link_rx.v
// spm_link_rx.v: brings the link pins into the clk_i domain
// assumes: sclk, cmd and cs/dat3 are asynchronous to clk_i and slow
// against it (sclk at most a quarter of clk_i)
module spm_link_rx (
  input wire clk_i,
  input wire rst_n_i,
  input wire sclk_i,
  input wire cmd_i,
  input wire cs_i,
  output reg sclk_rise_o,
  output wire cmd_o,
  output wire cs_o
);

  reg [2:0] meta_r;
  reg [2:0] sync_r;
  reg sclk_d_r;

  // -----------------------------------------------------------------
  // two-stage synchronisers, one per pin
  // -----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          // idle levels, so no false clock edge or start bit follows reset
          meta_r[g] <= (g == 0) ? 1'b0 : 1'b1;
          sync_r[g] <= (g == 0) ? 1'b0 : 1'b1; // clock parked low, cmd and cs pulled up
        end else begin
          meta_r[g] <= (g == 0) ? sclk_i : ((g == 1) ? cmd_i : cs_i);
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  // rising edge of the link clock, seen only on the second stage
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_d_r <= 1'b0;
      sclk_rise_o <= 1'b0;
    end else begin
      sclk_d_r <= sync_r[0];
      sclk_rise_o <= sync_r[0] & ~sclk_d_r;
    end
  end

  assign cmd_o = sync_r[1];
  assign cs_o = sync_r[2];

endmodule // spm_link_rx

//--- hdl/spm_powerup_mode.v
// spm_powerup_mode.v: card-side power-up, idle entry, bus mode select and
// line roles of the extended data lines and the SPI data-out pin.
// assumes: rst_n_i is the power-on reset; the command layer reports
// SET_BUS_WIDTH, ACMD42 and end of initialisation on the _i ports.
`include "spm_consts.vh"

module spm_powerup_mode (
  input wire clk_i,
  input wire rst_n_i,
  input wire sclk_i,
  input wire cmd_i,
  input wire cs_dat3_i,
  input wire init_done_i,
  input wire acmd42_stb_i,
  input wire acmd42_set_cd_i,
  input wire bus_wide_i,
  input wire dat_tx_i,
  input wire [3:1] dat_out_i,
  input wire sdio_en_i,
  input wire sdio_irq_i,
  input wire sdio_rd_wait_i,
  input wire spi_do_i,
  output reg idle_o,
  output reg init_clks_ok_o,
  output reg reset_cmd_o,
  output reg mode_locked_o,
  output reg mode_spi_o,
  output reg pullup_en_o,
  output reg [3:1] dat_o,
  output reg [3:1] dat_oe_n_o,
  output reg spi_do_o,
  output reg spi_do_oe_n_o,
  output reg byte_end_o
);

  // -----------------------------------------------------------------
  // reset release
  // -----------------------------------------------------------------
  reg rst_meta_r;
  reg rst_sync_r;
  wire rst_n;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  // -----------------------------------------------------------------
  // link pins
  // -----------------------------------------------------------------
  wire sclk_rise;
  wire cmd_s;
  wire cs_s;

  spm_link_rx u_rx (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .sclk_i(sclk_i),
    .cmd_i(cmd_i),
    .cs_i(cs_dat3_i),
    .sclk_rise_o(sclk_rise),
    .cmd_o(cmd_s),
    .cs_o(cs_s)
  );

  // -----------------------------------------------------------------
  // initial clock run watch
  // -----------------------------------------------------------------
  reg [6:0] init_cnt_r;

  // counts link clocks with the command line high; a low bit restarts it
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt_r <= 7'd0;
      init_clks_ok_o <= 1'b0;
    end else if (sclk_rise && !init_clks_ok_o) begin
      if (!cmd_s) begin
        init_cnt_r <= 7'd0;
      end else if (init_cnt_r == `SPM_INIT_CLKS - 7'd1) begin
        init_clks_ok_o <= 1'b1;
      end else begin
        init_cnt_r <= init_cnt_r + 7'd1;
      end
    end
  end

  // -----------------------------------------------------------------
  // command frame receiver
  // -----------------------------------------------------------------
  localparam ST_HUNT = 2'b01;
  localparam ST_FRAME = 2'b10;

  reg [1:0] st_r;
  reg [1:0] st_nxt;
  reg [47:0] shift_r;
  reg [5:0] bit_cnt_r;
  wire frame_gate;
  wire frame_done;
  wire is_reset_cmd;

  // once locked in SPI, only bits under an asserted chip select count
  assign frame_gate = !(mode_locked_o && mode_spi_o && cs_s);
  assign frame_done = (st_r == ST_FRAME) && sclk_rise && frame_gate
    && (bit_cnt_r == `SPM_FRAME_LAST);
  assign is_reset_cmd = !shift_r[`SPM_DIR_BIT] && shift_r[`SPM_DIR_BIT - 1]
    && (shift_r[`SPM_IDX_HI - 1:`SPM_IDX_LO - 1] == `SPM_RESET_IDX);

  // next state: a zero start bit opens a frame of fixed length
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_HUNT: begin
        if (sclk_rise && frame_gate && !cmd_s) begin
          st_nxt = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (!frame_gate || frame_done) begin
          st_nxt = ST_HUNT;
        end
      end
      default: st_nxt = ST_HUNT;
    endcase
  end

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_HUNT;
      shift_r <= 48'h0;
      bit_cnt_r <= 6'd0;
    end else begin
      st_r <= st_nxt;
      if (sclk_rise && frame_gate) begin
        shift_r <= {shift_r[46:0], cmd_s};
        bit_cnt_r <= (st_r == ST_FRAME) ? bit_cnt_r + 6'd1 : 6'd1;
      end
    end
  end

  // -----------------------------------------------------------------
  // mode decision and idle state
  // -----------------------------------------------------------------
  // the stop bit is not yet shifted in at the decision, so the frame sits one place low
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_spi_o <= `SPM_RST_SPI;
      mode_locked_o <= 1'b0;
      reset_cmd_o <= 1'b0;
      idle_o <= `SPM_RST_IDLE;
    end else begin
      reset_cmd_o <= frame_done && is_reset_cmd;
      if (frame_done && is_reset_cmd) begin
        idle_o <= 1'b1;
        if (!mode_locked_o) begin
          mode_spi_o <= ~cs_s;
          mode_locked_o <= 1'b1;
        end
      end else if (init_done_i) begin
        idle_o <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // card-detect pull-up
  // -----------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pullup_en_o <= `SPM_RST_PULLUP;
    end else if (acmd42_stb_i) begin
      pullup_en_o <= acmd42_set_cd_i;
    end
  end

  // -----------------------------------------------------------------
  // line roles of DAT1 to DAT3 (enable low means driving)
  // -----------------------------------------------------------------
  reg [3:1] dat_nxt;
  reg [3:1] oe_n_nxt;
  wire sd_mode;
  wire wide_tx;

  // until the mode is fixed the card treats the bus as SD
  assign sd_mode = !(mode_locked_o && mode_spi_o);
  assign wide_tx = sd_mode && bus_wide_i && dat_tx_i;

  always @* begin
    dat_nxt = 3'h7;
    oe_n_nxt = 3'h7;
    if (wide_tx) begin
      dat_nxt = dat_out_i;
      oe_n_nxt = 3'h0;
    end else if (sd_mode && sdio_en_i) begin
      if (sdio_irq_i) begin
        dat_nxt[1] = 1'b0;
        oe_n_nxt[1] = 1'b0;
      end
      if (sdio_rd_wait_i) begin
        dat_nxt[2] = 1'b0;
        oe_n_nxt[2] = 1'b0;
      end
    end
  end

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dat_o <= 3'h7;
      dat_oe_n_o <= 3'h7;
    end else begin
      dat_o <= dat_nxt;
      dat_oe_n_o <= oe_n_nxt;
    end
  end

  // -----------------------------------------------------------------
  // SPI data-out and byte framing
  // -----------------------------------------------------------------
  reg [2:0] byte_cnt_r;
  wire spi_sel;

  assign spi_sel = mode_locked_o && mode_spi_o && !cs_s;

  // push-pull out only while selected, so a shared line stays free
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      spi_do_o <= 1'b1;
      spi_do_oe_n_o <= 1'b1;
    end else begin
      spi_do_o <= spi_sel ? spi_do_i : 1'b1;
      spi_do_oe_n_o <= ~spi_sel;
    end
  end

  // bit count restarts at each chip select assertion
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      byte_cnt_r <= 3'd0;
      byte_end_o <= 1'b0;
    end else begin
      byte_end_o <= 1'b0;
      if (!spi_sel) begin
        byte_cnt_r <= 3'd0;
      end else if (sclk_rise) begin
        byte_cnt_r <= byte_cnt_r + 3'd1;
        byte_end_o <= (byte_cnt_r == `SPM_BYTE_LAST);
      end
    end
  end

endmodule // spm_powerup_mode

//--- bench/spm_powerup_mode_monitor.sv
// spm_powerup_mode_monitor.sv: port assertions of the power-up block
// assumes: bound to spm_powerup_mode, sees its ports only
module spm_pm_monitor (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic acmd42_stb_i,
  input wire logic acmd42_set_cd_i,
  input wire logic bus_wide_i,
  input wire logic dat_tx_i,
  input wire logic sdio_en_i,
  input wire logic sdio_irq_i,
  input wire logic sdio_rd_wait_i,
  input wire logic spi_do_i,
  input wire logic reset_cmd_o,
  input wire logic mode_locked_o,
  input wire logic mode_spi_o,
  input wire logic pullup_en_o,
  input wire logic [3:1] dat_o,
  input wire logic [3:1] dat_oe_n_o,
  input wire logic spi_do_o,
  input wire logic spi_do_oe_n_o,
  input wire logic byte_end_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // -------------------------------------------------
  // assertions
  // -------------------------------------------------
  a_pullup_cmd: assert property (acmd42_stb_i |=> pullup_en_o == $past(acmd42_set_cd_i))
    else $error("pull-up not set by acmd42");
  a_mode_held: assert property (mode_locked_o |=> mode_locked_o && $stable(mode_spi_o))
    else $error("bus mode changed after lock");
  a_lock_cause: assert property ($rose(mode_locked_o) |-> reset_cmd_o)
    else $error("mode locked without reset command");
  a_cmd_single: assert property (reset_cmd_o |=> !reset_cmd_o)
    else $error("reset command pulse too long");
  a_narrow_lines: assert property (!bus_wide_i && !sdio_en_i |=> dat_oe_n_o == 3'h7)
    else $error("extended data line driven");
  a_irq_line: assert property (sdio_en_i && sdio_irq_i && !(bus_wide_i && dat_tx_i)
    && !mode_spi_o |=> !dat_oe_n_o[1] && !dat_o[1])
    else $error("interrupt not on dat1");
  a_rd_wait: assert property (sdio_en_i && sdio_rd_wait_i && !(bus_wide_i && dat_tx_i)
    && !mode_spi_o |=> !dat_oe_n_o[2] && !dat_o[2])
    else $error("read wait not on dat2");
  a_spi_drive: assert property (!spi_do_oe_n_o |-> mode_spi_o && mode_locked_o
    && spi_do_o == $past(spi_do_i))
    else $error("data-out driven wrongly");
  a_byte_gap: assert property (byte_end_o |=> !byte_end_o [*8])
    else $error("byte end pulses too close");
endmodule // spm_pm_monitor

bind spm_powerup_mode spm_pm_monitor u_mon (.clk_i, .rst_n_i, .acmd42_stb_i,
  .acmd42_set_cd_i, .bus_wide_i, .dat_tx_i, .sdio_en_i, .sdio_irq_i, .sdio_rd_wait_i,
  .spi_do_i, .reset_cmd_o, .mode_locked_o, .mode_spi_o, .pullup_en_o, .dat_o,
  .dat_oe_n_o, .spi_do_o, .spi_do_oe_n_o, .byte_end_o);

//--- bench/spm_host_model.sv
// spm_host_model.sv: host side of the card link, clock, command and select
// assumes: the bench calls send and sel; 125 ns link clock
module spm_host_model (
  output logic sclk_o,
  output logic cmd_o,
  output logic cs_n_o,
  output logic [3:1] dat_oe_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // card unpowered: lines held low so no current feeds its pins
  task automatic power_off;
    sclk_o = 1'b0;
    cmd_o = 1'b0;
    cs_n_o = 1'b0;
    dat_oe_n_o = 3'h7;
  endtask
  initial power_off();
  // msb first; data moves in the low phase so the rise sees it settled
  task automatic send(input logic [79:0] v, input int n, input logic cs);
    cs_n_o = cs;
    for (int i = n - 1; i >= 0; i--) begin
      cmd_o = v[i];
      #62.5 sclk_o = 1'b1;
      #62.5 sclk_o = 1'b0;
    end
    cmd_o = 1'b1;
  endtask
  task automatic sel(input logic cs);
    cs_n_o = cs;
  endtask
endmodule // spm_host_model

//--- bench/spm_powerup_mode_tb_top.sv
// spm_powerup_mode_tb_top.sv: self-checking bench of the power-up block
// assumes: host model drives the link, bench drives command-layer inputs
module spm_powerup_mode_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, rst_n_i, init_done_i, acmd42_stb_i, acmd42_set_cd_i, bus_wide_i, dat_tx_i;
  logic sdio_en_i, sdio_irq_i, sdio_rd_wait_i, spi_do_i, idle_o, init_clks_ok_o;
  logic reset_cmd_o, mode_locked_o, mode_spi_o, pullup_en_o, spi_do_o, spi_do_oe_n_o;
  logic byte_end_o;
  logic [3:1] dat_out_i, dat_o, dat_oe_n_o;
  wire sclk_i, cmd_i, cs_dat3_i;
  wire [3:1] host_dat_oe_n;
  int miscompares, cmp_count, ncmd, nbyte;
  localparam logic [79:0] RST_FRAME = {32'h0, 2'b01, 6'h00, 32'h0, 7'h4a, 1'b1};
  spm_host_model host (.sclk_o(sclk_i), .cmd_o(cmd_i), .cs_n_o(cs_dat3_i),
    .dat_oe_n_o(host_dat_oe_n));
  spm_powerup_mode dut (.clk_i, .rst_n_i, .sclk_i, .cmd_i, .cs_dat3_i, .init_done_i,
    .acmd42_stb_i, .acmd42_set_cd_i, .bus_wide_i, .dat_tx_i, .dat_out_i, .sdio_en_i,
    .sdio_irq_i, .sdio_rd_wait_i, .spi_do_i, .idle_o, .init_clks_ok_o, .reset_cmd_o,
    .mode_locked_o, .mode_spi_o, .pullup_en_o, .dat_o, .dat_oe_n_o, .spi_do_o,
    .spi_do_oe_n_o, .byte_end_o);
  // -------------------------------------------------
  // clock and pulse counters
  // -------------------------------------------------
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (reset_cmd_o === 1'b1) ncmd++;
    if (byte_end_o === 1'b1) nbyte++;
  end
  // -------------------------------------------------
  // helpers
  // -------------------------------------------------
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // bounded wait for the n-th reset command pulse
  task automatic wcmd(input int n);
    for (int i = 0; i < 400 && ncmd != n; i++) tick(1);
    if (ncmd != n) begin
      miscompares++;
      final_report();
    end
  endtask
  // power cycle: lines low while off; off time far shorter than a real card's
  task automatic por;
    host.power_off();
    rst_n_i = 1'b0;
    tick(8);
    rst_n_i = 1'b1;
    tick(4);
    ncmd = 0;
  endtask
  // -------------------------------------------------
  // scenarios
  // -------------------------------------------------
  task automatic sc_power;
    chk(idle_o, 1'b1);
    chk(pullup_en_o, 1'b1);
    chk(dat_oe_n_o, 3'h7);
    chk(mode_locked_o, 1'b0);
    host.send('1, 73, 1'b1);
    tick(6);
    chk(init_clks_ok_o, 1'b0);
    host.send('1, 1, 1'b1);
    tick(6);
    chk(init_clks_ok_o, 1'b1);
  endtask
  task automatic sc_spi;
    nbyte = 0;
    host.send(RST_FRAME, 48, 1'b0);
    wcmd(1);
    chk(mode_spi_o, 1'b1);
    chk(mode_locked_o, 1'b1);
    chk(nbyte, 4'h0);
    tick(8);
    chk(spi_do_oe_n_o, 1'b0);
    chk(spi_do_o, 1'b0);
    spi_do_i = 1'b1;
    tick(2);
    chk(spi_do_o, 1'b1);
    nbyte = 0;
    host.send('1, 16, 1'b0);
    tick(6);
    chk(nbyte, 4'h2);
    // a deselect mid-byte restarts the byte count
    host.send('1, 4, 1'b0);
    host.sel(1'b1);
    tick(8);
    nbyte = 0;
    host.send('1, 12, 1'b0);
    tick(6);
    chk(nbyte, 4'h1);
    host.sel(1'b1);
    tick(8);
    chk(spi_do_oe_n_o, 1'b1);
  endtask
  // sd lock, then a low select at a later reset must not switch mode
  task automatic sc_sd;
    host.send(RST_FRAME, 48, 1'b1);
    wcmd(1);
    chk(mode_spi_o, 1'b0);
    host.send(RST_FRAME, 48, 1'b0);
    host.sel(1'b1);
    wcmd(2);
    chk(mode_spi_o, 1'b0);
    chk(idle_o, 1'b1);
    acmd42_stb_i = 1'b1;
    tick(1);
    acmd42_stb_i = 1'b0;
    tick(1);
    chk(pullup_en_o, 1'b0);
    dat_tx_i = 1'b1;
    dat_out_i = 3'h5;
    tick(2);
    chk(dat_oe_n_o, 3'h7);
    bus_wide_i = 1'b1;
    tick(2);
    chk(dat_oe_n_o, 3'h0);
    chk(dat_o, 3'h5);
    chk(host_dat_oe_n | dat_oe_n_o, 3'h7);
    dat_tx_i = 1'b0;
    sdio_en_i = 1'b1;
    sdio_irq_i = 1'b1;
    sdio_rd_wait_i = 1'b1;
    tick(2);
    chk(dat_oe_n_o, 3'h4);
    chk(dat_o[2:1], 2'h0);
    init_done_i = 1'b1;
    tick(2);
    chk(idle_o, 1'b0);
  endtask
  // all inputs defined at time zero, reset held from the start
  initial begin
    {clk_i, rst_n_i, init_done_i, acmd42_stb_i, acmd42_set_cd_i, bus_wide_i} = '0;
    {dat_tx_i, sdio_en_i, sdio_irq_i, sdio_rd_wait_i, spi_do_i, dat_out_i} = '0;
    {miscompares, cmp_count, ncmd, nbyte} = '0;
    por();
    sc_power();
    sc_spi();
    por();
    sc_power();
    sc_sd();
    final_report();
  end
endmodule // spm_powerup_mode_tb_top
